// ### core/rcbs_regs.svh
// Purpose: register offsets, field positions and timing counts of the reset cause block
// Assumes: byte-wide registers on a plain address/strobe port
// Notes:   flags live in the main module; this header holds definitions only
//
// Summary of operation
// - break during stop sets low-power exit flag
// - recovery counter held until stop recovery
// - five registers at fe00, fe01, fe03, fe04, fe05
// - writing zero or any reset clears flag
// - flag reads one after break exit
// - reset cause register holds six flags
// - reading reset cause clears all flags
// - power-on sets its flag, clears others
// - external pin reset sets pin flag
// - watchdog timeout sets watchdog flag
// - illegal opcode reset sets opcode flag
// - only illegal address fetch sets address flag
// - low-voltage reset sets undervoltage flag
// - break clear allow bit is read/write
// - break during wait also sets flag
// - recovery 4096 cycles, or 32 if short
// - two-step clears stay protected during break
`ifndef RCBS_REGS_SVH
`define RCBS_REGS_SVH

`define RCBS_ADDR_W          16
`define RCBS_OFF_BRK_STATUS  16'hfe00
`define RCBS_OFF_RST_CAUSE   16'hfe01
`define RCBS_OFF_BRK_CTRL    16'hfe03
`define RCBS_OFF_IRQ_STATUS  16'hfe04
`define RCBS_OFF_IRQ_MASK    16'hfe05

`define RCBS_BIT_LPEXIT      1
`define RCBS_BIT_POR         7
`define RCBS_BIT_PIN         6
`define RCBS_BIT_WDOG        5
`define RCBS_BIT_OPC         4
`define RCBS_BIT_FETCH       3
`define RCBS_BIT_UV          1
`define RCBS_BIT_CLR_ALLOW   7

`define RCBS_IRQ_LPEXIT      0
`define RCBS_IRQ_RECOV_DONE  1
`define RCBS_IRQ_W           2

`define RCBS_RECOV_LONG      13'h1000
`define RCBS_RECOV_SHORT     13'h0020
`define RCBS_CNT_W           13

`endif

// ### core/rcbs_pkg.sv
// Purpose: shared types of the reset cause block
// Assumes: included after rcbs_regs.svh
// Notes:   none
package rcbs_pkg;

    typedef enum logic [1:0] {
        RCBS_RUN     = 2'b00,
        RCBS_STOPPED = 2'b01,
        RCBS_RECOVER = 2'b10
    } rcbs_state_t;

    typedef struct packed {
        logic power_on;
        logic ext_pin;
        logic watchdog;
        logic bad_opcode;
        logic bad_fetch;
        logic undervolt;
    } rcbs_cause_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } rcbs_bus_t;

endpackage

// ### core/rcbs_recov_cnt.sv
// Purpose: stop recovery counter
// Assumes: crystal clock ticks arrive as enables from the clock generator
// Notes:   held cleared while hold_i is high
`timescale 1ns/100ps
`include "rcbs_regs.svh"
module rcbs_recov_cnt (
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   hold_i,
    input  wire logic                   xtick_i,
    input  wire logic                   short_i,
    output logic                        done_o
);
    logic [`RCBS_CNT_W-1:0] cnt_ff;
    logic [`RCBS_CNT_W-1:0] limit;

    assign limit = short_i ? `RCBS_RECOV_SHORT : `RCBS_RECOV_LONG;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff <= '0;
        end else if (hold_i) begin
            cnt_ff <= '0;
        end else if (xtick_i && (cnt_ff != limit)) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign done_o = (cnt_ff == limit);
endmodule

// ### core/rcbs_top.sv
// Purpose: reset cause, break exit status and stop recovery timing
// Assumes: cause strobes from reset sources stay valid past the internal reset release
// Notes:   cause strobes are latched at release, never under asynchronous reset
`timescale 1ns/100ps
`include "rcbs_regs.svh"
module rcbs_top (
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic [15:0]            addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic [7:0]                  rdata_o,
    input  wire logic                   cause_por_i,
    input  wire logic                   cause_pin_i,
    input  wire logic                   cause_wdog_i,
    input  wire logic                   cause_opc_i,
    input  wire logic                   cause_fetch_i,
    input  wire logic                   cause_uv_i,
    input  wire logic                   stop_exec_i,
    input  wire logic                   wait_exec_i,
    input  wire logic                   wake_i,
    input  wire logic                   break_irq_i,
    input  wire logic                   break_mode_i,
    input  wire logic                   short_recovery_select_i,
    input  wire logic                   crystal_clock_tick_i,
    input  wire logic                   two_step_first_i,
    input  wire logic                   two_step_second_i,
    output logic                        flag_clear_ok_o,
    output logic                        two_step_clear_o,
    output logic                        stop_mode_o,
    output logic                        recov_done_o,
    output logic                        irq_o
);
    logic                   rst_meta_ff;
    logic                   rst_sync_ff;
    logic                   rst_n;
    logic                   first_ff;
    rcbs_pkg::rcbs_cause_t  cause_ff;
    rcbs_pkg::rcbs_cause_t  nxt_cause;
    rcbs_pkg::rcbs_state_t  state_ff;
    rcbs_pkg::rcbs_state_t  nxt_state;
    logic                   lpexit_ff;
    logic                   in_wait_ff;
    logic                   clr_allow_ff;
    logic                   step_armed_ff;
    logic [7:0]             rdata_ff;
    logic [7:0]             rd_mux;
    logic [`RCBS_IRQ_W-1:0] irq_stat_ff;
    logic [`RCBS_IRQ_W-1:0] irq_mask_ff;
    logic [`RCBS_IRQ_W-1:0] irq_evt;
    logic                   cnt_done;
    logic                   done_q_ff;
    logic                   lp_evt;
    logic                   hit_stat;
    logic                   hit_cause;
    logic                   hit_ctrl;
    logic                   hit_istat;
    logic                   hit_imask;
    logic                   nxt_in_wait;
    logic                   nxt_lpexit;
    logic                   nxt_clr_allow;
    logic                   nxt_step_armed;
    logic [`RCBS_IRQ_W-1:0] nxt_irq_mask;
    logic [7:0]             nxt_rdata;
    logic                   nxt_done;
    logic [`RCBS_IRQ_W-1:0] irq_pend;
    logic                   wr_stat;
    logic                   wr_ctrl;
    logic                   wr_istat;
    logic                   wr_imask;
    logic                   rd_cause;

    // release reset through two flops so no flop leaves reset on a marginal edge
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rst_n = rst_sync_ff;

    assign hit_stat  = (addr_i == `RCBS_OFF_BRK_STATUS);
    assign hit_cause = (addr_i == `RCBS_OFF_RST_CAUSE);
    assign hit_ctrl  = (addr_i == `RCBS_OFF_BRK_CTRL);
    assign hit_istat = (addr_i == `RCBS_OFF_IRQ_STATUS);
    assign hit_imask = (addr_i == `RCBS_OFF_IRQ_MASK);

    // qualified strobes, so every register sees the same decode
    assign wr_stat  = wr_i && hit_stat;
    assign wr_ctrl  = wr_i && hit_ctrl;
    assign wr_istat = wr_i && hit_istat;
    assign wr_imask = wr_i && hit_imask;
    assign rd_cause = rd_i && hit_cause;

    // causes sampled on the first clocked cycle after release
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            first_ff <= 1'b1;
        end else begin
            first_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_cause = cause_ff;
        if (first_ff) begin
            if (cause_por_i) begin
                nxt_cause = '0;
                nxt_cause.power_on = 1'b1;
            end else begin
                nxt_cause.power_on   = 1'b0;
                nxt_cause.ext_pin    = cause_pin_i;
                nxt_cause.watchdog   = cause_wdog_i;
                nxt_cause.bad_opcode = cause_opc_i;
                nxt_cause.bad_fetch  = cause_fetch_i;
                nxt_cause.undervolt  = cause_uv_i;
            end
        end else if (rd_cause) begin
            // a read in the load cycle is lost: the load has priority
            nxt_cause = '0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cause_ff <= '0;
        end else begin
            cause_ff <= nxt_cause;
        end
    end

    // low-power state: stop holds the counter, recovery runs it
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            rcbs_pkg::RCBS_RUN: begin
                if (stop_exec_i) begin
                    nxt_state = rcbs_pkg::RCBS_STOPPED;
                end
            end
            rcbs_pkg::RCBS_STOPPED: begin
                if (wake_i || break_irq_i) begin
                    nxt_state = rcbs_pkg::RCBS_RECOVER;
                end
            end
            rcbs_pkg::RCBS_RECOVER: begin
                if (cnt_done) begin
                    nxt_state = rcbs_pkg::RCBS_RUN;
                end
            end
            default: begin
                nxt_state = rcbs_pkg::RCBS_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= rcbs_pkg::RCBS_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_comb begin
        nxt_in_wait = in_wait_ff;
        if (wait_exec_i) begin
            nxt_in_wait = 1'b1;
        end else if (wake_i || break_irq_i) begin
            nxt_in_wait = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            in_wait_ff <= 1'b0;
        end else begin
            in_wait_ff <= nxt_in_wait;
        end
    end

    rcbs_recov_cnt u_recov_cnt (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_n),
        .hold_i    (state_ff != rcbs_pkg::RCBS_RECOVER),
        .xtick_i   (crystal_clock_tick_i),
        .short_i   (short_recovery_select_i),
        .done_o    (cnt_done)
    );

    assign lp_evt = break_irq_i
                    && ((state_ff == rcbs_pkg::RCBS_STOPPED) || in_wait_ff);

    // set wins over a same-cycle write of zero so a break exit is never lost
    always_comb begin
        nxt_lpexit = lpexit_ff;
        if (lp_evt) begin
            nxt_lpexit = 1'b1;
        end else if (wr_stat && !wdata_i[`RCBS_BIT_LPEXIT]) begin
            nxt_lpexit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lpexit_ff <= 1'b0;
        end else begin
            lpexit_ff <= nxt_lpexit;
        end
    end

    always_comb begin
        nxt_clr_allow = clr_allow_ff;
        if (wr_ctrl) begin
            nxt_clr_allow = wdata_i[`RCBS_BIT_CLR_ALLOW];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            clr_allow_ff <= 1'b0;
        end else begin
            clr_allow_ff <= nxt_clr_allow;
        end
    end

    assign flag_clear_ok_o = !break_mode_i || clr_allow_ff;

    // a first step taken before break stays armed; the second disarms only when allowed
    always_comb begin
        nxt_step_armed = step_armed_ff;
        if (two_step_first_i) begin
            nxt_step_armed = 1'b1;
        end else if (two_step_second_i && flag_clear_ok_o) begin
            nxt_step_armed = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            step_armed_ff <= 1'b0;
        end else begin
            step_armed_ff <= nxt_step_armed;
        end
    end

    assign two_step_clear_o = step_armed_ff && two_step_second_i
                              && (!break_mode_i || clr_allow_ff);

    // recovery done as a one-cycle event
    assign nxt_done = (state_ff == rcbs_pkg::RCBS_RECOVER) && cnt_done;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            done_q_ff <= 1'b0;
        end else begin
            done_q_ff <= nxt_done;
        end
    end

    assign irq_evt = {done_q_ff, lp_evt};

    genvar gi;
    generate
        for (gi = 0; gi < `RCBS_IRQ_W; gi = gi + 1) begin : g_irq
            logic nxt_stat;

            // set wins over a same-cycle write of one
            always_comb begin
                nxt_stat = irq_stat_ff[gi];
                if (irq_evt[gi]) begin
                    nxt_stat = 1'b1;
                end else if (wr_istat && wdata_i[gi]) begin
                    nxt_stat = 1'b0;
                end
            end

            always_ff @(posedge ref_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    irq_stat_ff[gi] <= 1'b0;
                end else begin
                    irq_stat_ff[gi] <= nxt_stat;
                end
            end
        end
    endgenerate

    always_comb begin
        nxt_irq_mask = irq_mask_ff;
        if (wr_imask) begin
            nxt_irq_mask = wdata_i[`RCBS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_ff <= '0;
        end else begin
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    assign irq_pend = irq_stat_ff & irq_mask_ff;
    assign irq_o    = |irq_pend;

    // unmapped addresses and unused bits read zero
    always_comb begin
        rd_mux = 8'h00;
        if (hit_stat) begin
            rd_mux[`RCBS_BIT_LPEXIT] = lpexit_ff;
        end else if (hit_cause) begin
            rd_mux[`RCBS_BIT_POR]   = cause_ff.power_on;
            rd_mux[`RCBS_BIT_PIN]   = cause_ff.ext_pin;
            rd_mux[`RCBS_BIT_WDOG]  = cause_ff.watchdog;
            rd_mux[`RCBS_BIT_OPC]   = cause_ff.bad_opcode;
            rd_mux[`RCBS_BIT_FETCH] = cause_ff.bad_fetch;
            rd_mux[`RCBS_BIT_UV]    = cause_ff.undervolt;
        end else if (hit_ctrl) begin
            rd_mux[`RCBS_BIT_CLR_ALLOW] = clr_allow_ff;
        end else if (hit_istat) begin
            rd_mux[`RCBS_IRQ_W-1:0] = irq_stat_ff;
        end else if (hit_imask) begin
            rd_mux[`RCBS_IRQ_W-1:0] = irq_mask_ff;
        end
    end

    // read data stand for one cycle only, so a stale value is never mistaken for a read
    always_comb begin
        nxt_rdata = 8'h00;
        if (rd_i) begin
            nxt_rdata = rd_mux;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_o      = rdata_ff;
    assign stop_mode_o  = (state_ff == rcbs_pkg::RCBS_STOPPED);
    assign recov_done_o = done_q_ff;
endmodule

// ### dv/rcbs_props.sv
// Purpose: port checks of the reset cause block
// Assumes: bench leaves one idle cycle between strobes and events
// Notes:   fe04/fe05 are the irq status and mask, counted as mapped
`timescale 1ns/100ps
module rcbs_props (
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        stop_exec_i,
    input wire logic        break_irq_i,
    input wire logic        break_mode_i,
    input wire logic        two_step_second_i,
    input wire logic        flag_clear_ok_o,
    input wire logic        two_step_clear_o,
    input wire logic        stop_mode_o,
    input wire logic        recov_done_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its slot");
    a_unmapped_zero: assert property (rd_i && !(addr_i inside
        {16'hfe00, 16'hfe01, 16'hfe03, 16'hfe04, 16'hfe05}) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_status_unused: assert property (rd_i && addr_i == 16'hfe00 |=> !(rdata_o & 8'hfd))
        else $error("unused status bits set");
    a_cause_unused: assert property (rd_i && addr_i == 16'hfe01 |=> !(rdata_o & 8'h05))
        else $error("unused cause bits set");
    a_cause_rdclr: assert property (rd_i && addr_i == 16'hfe01 ##2
        rd_i && addr_i == 16'hfe01 |=> rdata_o == 8'h00)
        else $error("cause flags survive a read");
    a_ctrl_rw: assert property (wr_i && addr_i == 16'hfe03 ##2
        rd_i && addr_i == 16'hfe03 |=> rdata_o == ($past(wdata_i, 3) & 8'h80))
        else $error("control readback wrong");
    a_lpexit_set: assert property (stop_exec_i && !stop_mode_o ##2 break_irq_i ##2
        rd_i && addr_i == 16'hfe00 |=> rdata_o[1])
        else $error("break in stop left exit flag clear");
    a_clear_ok: assert property (!break_mode_i |-> flag_clear_ok_o)
        else $error("clearing blocked outside break");
    a_two_step: assert property (two_step_clear_o |-> two_step_second_i && flag_clear_ok_o)
        else $error("two-step clear while protected");
    a_stop_hold: assert property (stop_exec_i && !stop_mode_o |=> stop_mode_o [*2])
        else $error("stop state not held");
    a_no_done_stop: assert property (stop_mode_o |-> !recov_done_o)
        else $error("recovery done while stopped");
    c_lpexit: cover property (rd_i && addr_i == 16'hfe00 ##1 rdata_o[1]);
    c_recov: cover property (recov_done_o);
    c_two_step: cover property (two_step_clear_o);
endmodule

// ### dv/rcbs_cpu_model.sv
// Purpose: cpu side of the register port and of the low-power events
// Assumes: every request changes just after a rising edge
// Notes:   crystal ticks come every cycle, or every second cycle while slow_i is high
`timescale 1ns/100ps
module rcbs_cpu_model (
    input  wire logic        clk_i,
    input  wire logic [7:0]  rdata_i,
    output logic      [15:0] addr_o,
    output logic      [7:0]  wdata_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [3:0]  evt_o,
    output logic             tick_o,
    input  wire logic        slow_i
);
    // evt_o bits: stop, wait, wake, break
    initial begin
        addr_o = 16'h0000;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        evt_o = 4'h0;
    end
    // slow_i halves the tick rate so the counter enable is really exercised
    always @(posedge clk_i) tick_o <= slow_i ? ~tick_o : 1'b1;
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
    task automatic ev(input logic [3:0] v);
        @(posedge clk_i);
        evt_o <= v;
        @(posedge clk_i);
        evt_o <= 4'h0;
    endtask
    // break handler end: go back to wait if break ended the low-power mode
    task automatic resleep();
        logic [7:0] d;
        rd(16'hfe00, d);
        if (d[1]) begin
            wr(16'hfe00, 8'h00);
            ev(4'h4);
        end
    endtask
endmodule

// ### dv/rcbs_top_tb.sv
// Purpose: register-level bench of the reset cause block
// Assumes: cpu model drives the port, the low-power events and the ticks, bench drives the rest
// Notes:   recovery is timed with ticks on every cycle, then on every second one
`timescale 1ns/100ps
module rcbs_top_tb;
    logic        ref_clk_i, rst_b_i, wr, rd, tick, brk_mode, short_sel, slow;
    logic        done, clr_ok, ts_clr, stop_m, irq;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata;
    logic [3:0]  evt;
    logic [5:0]  cause;
    logic [1:0]  ts;
    int          fail_count, check_count, n;
    rcbs_cpu_model cpu (.clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .evt_o(evt), .tick_o(tick), .slow_i(slow));
    rcbs_top rcbs_top_inst (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cause_por_i(cause[5]),
        .cause_pin_i(cause[4]), .cause_wdog_i(cause[3]), .cause_opc_i(cause[2]),
        .cause_fetch_i(cause[1]), .cause_uv_i(cause[0]), .stop_exec_i(evt[3]),
        .wait_exec_i(evt[2]), .wake_i(evt[1]), .break_irq_i(evt[0]),
        .break_mode_i(brk_mode), .short_recovery_select_i(short_sel),
        .crystal_clock_tick_i(tick), .two_step_first_i(ts[0]), .two_step_second_i(ts[1]),
        .flag_clear_ok_o(clr_ok), .two_step_clear_o(ts_clr), .stop_mode_o(stop_m),
        .recov_done_o(done), .irq_o(irq));
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic rc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        cpu.rd(a, d);
        chk(d, e);
    endtask
    // cause levels stay up past the internal release, as the sources do
    task automatic do_reset(input logic [5:0] c);
        @(posedge ref_clk_i);
        rst_b_i <= 1'b0;
        cause <= c;
        repeat (12) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        cause <= 6'h00;
    endtask
    task automatic wait_done(output int k);
        k = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            k++;
            if (k > 5000) begin
                fail_count++;
                return;
            end
        end while (done !== 1'b1);
    endtask
    task automatic st(input logic [1:0] v, input logic e);
        @(posedge ref_clk_i);
        ts <= v;
        #1;
        chk({7'h00, ts_clr}, {7'h00, e});
        @(posedge ref_clk_i);
        ts <= 2'b00;
    endtask
    initial begin
        fail_count = 0;
        check_count = 0;
        rst_b_i = 1'b0;
        cause = 6'h00;
        brk_mode = 1'b0;
        short_sel = 1'b1;
        slow = 1'b0;
        ts = 2'b00;
        @(posedge ref_clk_i);
        do_reset(6'h20);
        rc(16'hfe01, 8'h80);
        rc(16'hfe01, 8'h00);
        rc(16'hfe00, 8'h00);
        cpu.wr(16'hfe02, 8'hff);
        rc(16'hfe02, 8'h00);
        rc(16'hfe03, 8'h00);
        cpu.wr(16'hfe03, 8'hff);
        rc(16'hfe03, 8'h80);
        @(posedge ref_clk_i) brk_mode <= 1'b1;
        #2;
        chk({7'h00, clr_ok}, 8'h01);
        cpu.wr(16'hfe03, 8'h00);
        #1;
        chk({7'h00, clr_ok}, 8'h00);
        @(posedge ref_clk_i) brk_mode <= 1'b0;
        st(2'b01, 1'b0);
        @(posedge ref_clk_i) brk_mode <= 1'b1;
        st(2'b10, 1'b0);
        @(posedge ref_clk_i) brk_mode <= 1'b0;
        st(2'b10, 1'b1);
        cpu.wr(16'hfe04, 8'h03);
        cpu.wr(16'hfe05, 8'h01);
        cpu.ev(4'h8);
        cpu.ev(4'h1);
        rc(16'hfe00, 8'h02);
        chk({7'h00, irq}, 8'h01);
        wait_done(n);
        cpu.wr(16'hfe00, 8'hff);
        rc(16'hfe00, 8'h02);
        cpu.wr(16'hfe00, 8'h00);
        rc(16'hfe00, 8'h00);
        cpu.wr(16'hfe05, 8'h00);
        #1;
        chk({7'h00, irq}, 8'h00);
        cpu.wr(16'hfe04, 8'h03);
        rc(16'hfe04, 8'h00);
        cpu.ev(4'h4);
        cpu.ev(4'h1);
        rc(16'hfe00, 8'h02);
        cpu.resleep();
        cpu.ev(4'h2);
        rc(16'hfe00, 8'h00);
        // recovery counter must not run while stopped: 50 idle cycles first
        for (int s = 0; s < 3; s++) begin
            int e;
            e = (s == 0) ? 32 : (s == 1) ? 4096 : 64;
            @(posedge ref_clk_i);
            short_sel <= (s != 1);
            slow <= (s == 2);
            cpu.ev(4'h8);
            repeat (50) @(posedge ref_clk_i);
            cpu.ev(4'h2);
            wait_done(n);
            chk({7'h00, n >= e - 1 && n <= e + 3}, 8'h01);
        end
        rc(16'hfe00, 8'h00);
        cpu.ev(4'h8);
        cpu.ev(4'h1);
        for (int i = 0; i < 5; i++) begin
            logic [5:0] c;
            c = 6'h10 >> i;
            do_reset(c);
            rc(16'hfe00, 8'h00);
            rc(16'hfe01, {c[5:1], 1'b0, c[0], 1'b0});
        end
        give_verdict();
    end
endmodule
bind rcbs_top rcbs_props rcbs_props_inst (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .stop_exec_i(stop_exec_i),
    .break_irq_i(break_irq_i), .break_mode_i(break_mode_i),
    .two_step_second_i(two_step_second_i), .flag_clear_ok_o(flag_clear_ok_o),
    .two_step_clear_o(two_step_clear_o), .stop_mode_o(stop_mode_o),
    .recov_done_o(recov_done_o));
